/* amps_pkg.sv */
// amps_pkg: constants shared by the mode/power-down sequencing block.
// assumes: a 50 MHz system clock and a free-running conversion clock input.
package amps_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on apb)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CFG_WRITE = 8'h00;
  localparam logic [7:0] REG_CHAN_CFG  = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_RESULT    = 8'h0C;
  localparam logic [7:0] REG_STRAPS    = 8'h10;

  // ----------------------------------------------------------------
  // configuration write word fields
  // ----------------------------------------------------------------
  localparam int CFG_ADDR_LSB      = 0;
  localparam int CFG_PAIR_BIT      = 3;
  localparam int CFG_SIGNED_BIT    = 4;
  localparam int CFG_SUPPRESS_BIT  = 5;
  localparam int CFG_SLEEP_BIT     = 6;
  localparam int CFG_ENABLE_BIT    = 7;

  // status bits
  localparam int ST_BUSY_N_BIT  = 0;
  localparam int ST_SLEEP_BIT   = 1;
  localparam int ST_HARD_BIT    = 2;
  localparam int ST_REFUSED_BIT = 3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAN_CFG_RESET  = 8'h00;
  localparam int         CYC_PER_CHAN    = 9;
  localparam int         CLK_PER_CYC     = 2;
  localparam int         CONV_PER_CHAN   = CYC_PER_CHAN * CLK_PER_CYC;

  typedef enum logic [1:0] {
    MODE_LOW,
    MODE_HIGH,
    MODE_FLOAT
  } amps_strap_e;

endpackage : amps_pkg

/* amps_seq_if.sv */
// amps_seq_if: start/busy link between control and sequencer.
// assumes: one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface amps_seq_if;
  logic       start;
  logic [7:0] chan_mask;
  logic       conv_tick;
  logic       busy;
  logic [2:0] cur_chan;
  logic       chan_done;
  modport ctrl (output start, output chan_mask, output conv_tick,
                input busy, input cur_chan, input chan_done);
  modport seq  (input start, input chan_mask, input conv_tick,
                output busy, output cur_chan, output chan_done);
endinterface : amps_seq_if
`default_nettype wire

/* amps_sequencer.sv */
// amps_sequencer: steps through the selected channels, lowest first,
// spending a fixed count of conversion-clock ticks on each one.
// assumes: conv_tick is a one-cycle pulse per rising edge of the conversion clock.
`timescale 1ns/1ps
`default_nettype none
module amps_sequencer (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic ce,
  amps_seq_if.seq   sq
);

  typedef enum logic {SEQ_IDLE, SEQ_RUN} amps_seq_e;

  amps_seq_e  state_q, state_d;
  logic [2:0] chan_q, chan_d;
  logic [7:0] left_q, left_d;
  logic [4:0] tick_q, tick_d;
  logic       done_d;

  function automatic logic [2:0] amps_lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : amps_lowest

  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    left_d  = left_q;
    tick_d  = tick_q;
    done_d  = 1'b0;
    unique case (state_q)
      SEQ_IDLE: begin
        if (sq.start && (sq.chan_mask != 8'h00)) begin
          state_d = SEQ_RUN;
          chan_d  = amps_lowest(sq.chan_mask);
          left_d  = sq.chan_mask;
          tick_d  = 5'h00;
        end
      end
      SEQ_RUN: begin
        if (sq.conv_tick) begin
          if (tick_q == 5'(amps_pkg::CONV_PER_CHAN - 1)) begin
            tick_d = 5'h00;
            done_d = 1'b1;
            left_d = left_q & ~(8'h01 << chan_q);
            if ((left_q & ~(8'h01 << chan_q)) == 8'h00) begin
              state_d = SEQ_IDLE;
            end else begin
              chan_d = amps_lowest(left_q & ~(8'h01 << chan_q));
            end
          end else begin
            tick_d = tick_q + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= SEQ_IDLE;
      chan_q  <= 3'h0;
      left_q  <= 8'h00;
      tick_q  <= 5'h00;
    end else if (ce) begin
      state_q <= state_d;
      chan_q  <= chan_d;
      left_q  <= left_d;
      tick_q  <= tick_d;
    end
  end

  assign sq.busy      = (state_q == SEQ_RUN);
  assign sq.cur_chan  = chan_q;
  // done pulses while cur_chan still names the finished channel;
  // a registered pulse would store each result but the run's last in the next selected channel's slot
  assign sq.chan_done = done_d;

endmodule : amps_sequencer
`default_nettype wire

/* amps_ctrl.sv */
// amps_ctrl: mode straps, configuration writes, sleep, conversion start,
// result memory and apb access for an 8-channel 8-bit converter.
// assumes: apb master per protocol; straps, conv_clk and sample inputs
// synchronous to clock; sample_code carries the converter's raw output.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module amps_ctrl (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  mode_strap,
  input  wire logic        neg_rail_strap,
  input  wire logic        conv_clk,
  input  wire logic [7:0]  sample_code,
  input  wire logic        sample_neg,
  output logic             busy_n,
  output logic             sleep_active,
  output logic [2:0]       conv_chan
);

  amps_seq_if sq ();
  amps_sequencer u_seq (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .sq    (sq)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] chan_cfg_q [8];
  logic [7:0] chan_cfg_d [8];
  logic [7:0] ram_q [8];
  logic [7:0] ram_d [8];
  logic       sleep_q, sleep_d;
  logic [2:0] ptr_q, ptr_d;
  logic       refused_q, refused_d;
  logic       cclk_q;
  logic       start_q, start_d;
  logic [7:0] mask_q, mask_d;
  logic       busy_n_q, sleep_o_q;
  logic [2:0] chan_o_q;
  logic       pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  amps_pkg::amps_strap_e strap;
  logic wr_acc, wr_req, rd_acc, hard_mode;
  logic [2:0] waddr;

  assign strap = (mode_strap == 2'b00) ? amps_pkg::MODE_LOW :
                 (mode_strap == 2'b01) ? amps_pkg::MODE_HIGH :
                 amps_pkg::MODE_FLOAT;
  assign hard_mode = (strap != amps_pkg::MODE_FLOAT);
  // a write takes effect where pready is seen, the strobe's rising edge;
  // its address is checked one edge earlier so pslverr rides with pready
  assign wr_req = psel && penable && pwrite && !pready_q;
  assign wr_acc = psel && penable && pwrite && pready_q;
  assign rd_acc = psel && penable && !pwrite && !pready_q;
  assign waddr  = pwdata[amps_pkg::CFG_ADDR_LSB +: 3];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] amps_mask(input logic [7:0] cfg [8],
                                           input logic hard,
                                           input logic pair_only);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (hard) begin
        m[i] = pair_only ? (i % 2 == 1) : 1'b1;
      end else if (cfg[i][amps_pkg::CFG_ENABLE_BIT]) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : amps_mask

  function automatic logic [7:0] amps_code(input logic [7:0] c,
                                           input logic neg,
                                           input logic pair,
                                           input logic signd);
    return (pair && !signd && neg) ? 8'h00 : c;
  endfunction : amps_code

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic pair_sel, signd_sel;
  always_comb begin
    if (hard_mode) begin
      pair_sel  = (strap == amps_pkg::MODE_HIGH);
      signd_sel = neg_rail_strap;
    end else begin
      pair_sel  = chan_cfg_q[sq.cur_chan][amps_pkg::CFG_PAIR_BIT];
      signd_sel = chan_cfg_q[sq.cur_chan][amps_pkg::CFG_SIGNED_BIT];
    end
  end

  always_comb begin
    chan_cfg_d = chan_cfg_q;
    ram_d      = ram_q;
    sleep_d    = sleep_q;
    ptr_d      = ptr_q;
    refused_d  = refused_q;
    start_d    = 1'b0;
    mask_d     = mask_q;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    prdata_d   = prdata_q;
    if (sq.chan_done) begin
      ram_d[sq.cur_chan] = amps_code(sample_code, sample_neg,
                                     pair_sel, signd_sel);
    end
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
    end
    if (wr_acc && paddr == amps_pkg::REG_CFG_WRITE) begin
      sleep_d = pwdata[amps_pkg::CFG_SLEEP_BIT];
      ptr_d   = waddr;
      if (!hard_mode) begin
        // the addressed channel's new config byte takes effect now
        chan_cfg_d[waddr] = pwdata[7:0];
      end
      if (!pwdata[amps_pkg::CFG_SUPPRESS_BIT]
          && !pwdata[amps_pkg::CFG_SLEEP_BIT] && !sq.busy) begin
        start_d = 1'b1;
        mask_d  = amps_mask(chan_cfg_d, hard_mode,
                            strap == amps_pkg::MODE_HIGH);
        ptr_d   = 3'h0;
      end
    end else if (wr_acc && paddr == amps_pkg::REG_CHAN_CFG) begin
      if (!hard_mode) begin
        chan_cfg_d[waddr] = pwdata[15:8];
      end
    end else if (wr_acc && paddr == amps_pkg::REG_STATUS) begin
      refused_d = 1'b0;
    end
    if (wr_req && paddr != amps_pkg::REG_CFG_WRITE
        && paddr != amps_pkg::REG_CHAN_CFG
        && paddr != amps_pkg::REG_STATUS) begin
      pslverr_d = 1'b1;
    end
    if (rd_acc) begin
      unique case (paddr)
        amps_pkg::REG_STATUS: begin
          prdata_d = {28'h0000000, refused_q, hard_mode, sleep_q,
                      !sq.busy};
        end
        amps_pkg::REG_CHAN_CFG: prdata_d = {24'h000000, chan_cfg_q[ptr_q]};
        amps_pkg::REG_STRAPS: begin
          prdata_d = {29'h0000000, neg_rail_strap, mode_strap};
        end
        amps_pkg::REG_RESULT: begin
          if (sleep_q || sq.busy) begin
            prdata_d  = 32'h00000000;
            pslverr_d = 1'b1;
            refused_d = 1'b1;
          end else begin
            prdata_d = {24'h000000, ram_q[ptr_q]};
            ptr_d    = ptr_q + 3'h1;
          end
        end
        default: begin
          prdata_d  = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  // tick from the free-running conversion clock
  assign sq.conv_tick = conv_clk && !cclk_q;
  assign sq.start     = start_q;
  assign sq.chan_mask = mask_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        chan_cfg_q[i] <= amps_pkg::CHAN_CFG_RESET;
        ram_q[i]      <= 8'h00;
      end
      sleep_q   <= 1'b0;
      ptr_q     <= 3'h0;
      refused_q <= 1'b0;
      cclk_q    <= 1'b0;
      start_q   <= 1'b0;
      mask_q    <= 8'h00;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      busy_n_q  <= 1'b1;
      sleep_o_q <= 1'b0;
      chan_o_q  <= 3'h0;
    end else if (ce) begin
      chan_cfg_q <= chan_cfg_d;
      ram_q      <= ram_d;
      sleep_q    <= sleep_d;
      ptr_q      <= ptr_d;
      refused_q  <= refused_d;
      cclk_q     <= conv_clk;
      start_q    <= start_d;
      mask_q     <= mask_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      busy_n_q   <= !(sq.busy || start_d || start_q);
      sleep_o_q  <= sleep_d;
      chan_o_q   <= sq.cur_chan;
    end
  end

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign busy_n       = busy_n_q;
  assign sleep_active = sleep_o_q;
  assign conv_chan    = chan_o_q;

endmodule : amps_ctrl
`default_nettype wire

/* amps_ctrl_monitor.sv */
// amps_ctrl_monitor: port checks bound onto amps_ctrl.
// assumes: one clock domain; ce only dropped while the bus is idle.
`timescale 1ns/1ps
`default_nettype none
module amps_ctrl_monitor (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  mode_strap,
  input wire logic        busy_n,
  input wire logic        sleep_active,
  input wire logic [2:0]  conv_chan
);
  // --------------------
  // accepted transfers
  // --------------------
  wire acc = psel && penable && pready;
  wire wr0 = acc && pwrite && paddr == amps_pkg::REG_CFG_WRITE;
  wire rdr = acc && !pwrite && paddr == amps_pkg::REG_RESULT;
  wire slp = pwdata[amps_pkg::CFG_SLEEP_BIT];
  wire sup = pwdata[amps_pkg::CFG_SUPPRESS_BIT];
  // start checks cover register mode only (mode_strap[1] set) and skip strapped mode
  wire regm = mode_strap[1];
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  // --------------------
  // assertions
  // --------------------
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  sleep_set_a: assert property (wr0 && slp |-> ##[0:2] sleep_active)
    else $error("sleep request not applied");
  sleep_clr_a: assert property (wr0 && !slp |-> ##[0:2] !sleep_active)
    else $error("sleep not left on write of zero");
  read_refuse_a: assert property (rdr && sleep_active |->
    pslverr && prdata == 32'h0)
    else $error("result read served while asleep");
  sleep_idle_a: assert property (sleep_active && busy_n && !psel
    |=> busy_n)
    else $error("conversion started while asleep");
  suppress_hold_a: assert property (wr0 && sup && busy_n && regm
    |=> busy_n [*2])
    else $error("suppressed write started a conversion");
  start_taken_a: assert property (wr0 && !sup && !slp && busy_n && regm
    |-> ##[1:2] !busy_n)
    else $error("start write did not start");
  // the first channel of a run shows up two edges after busy_n falls
  chan_order_a: assert property (!busy_n && !$past(busy_n, 3) &&
    $changed(conv_chan) |-> conv_chan > $past(conv_chan))
    else $error("channel order not ascending");
  cover property (wr0 && slp);
  cover property (rdr && pslverr);
  cover property ($rose(busy_n));
endmodule : amps_ctrl_monitor

bind amps_ctrl amps_ctrl_monitor u_mon (.clock(clock), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .mode_strap(mode_strap), .busy_n(busy_n),
  .sleep_active(sleep_active), .conv_chan(conv_chan));
`default_nettype wire

/* amps_front_model.sv */
// amps_front_model: converter front end facing amps_ctrl.
// assumes: runs off the bench clock; HALF in system cycles.
`timescale 1ns/1ps
`default_nettype none
module amps_front_model #(
  parameter int HALF = 2
) (
  input  wire logic       clock,
  input  wire logic [2:0] conv_chan,
  input  wire logic       neg_in,
  output logic            conv_clk,
  output logic [7:0]      sample_code,
  output logic            sample_neg
);
  int   cnt = 0;
  logic clk_q = 1'b0;
  // free running, also between sequences
  always @(posedge clock) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) clk_q <= ~clk_q;
  end
  assign conv_clk = clk_q;
  // code follows the channel so result order is visible
  assign sample_code = 8'h10 + {5'h00, conv_chan};
  assign sample_neg = neg_in;
endmodule : amps_front_model
`default_nettype wire

/* tb_top.sv */
// tb_top: self-checking bench driving amps_ctrl over apb.
// assumes: amps_front_model stands in for the converter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] CW = amps_pkg::REG_CFG_WRITE;
  localparam logic [7:0] RS = amps_pkg::REG_RESULT;
  localparam logic [7:0] ST = amps_pkg::REG_STATUS;
  localparam int         P = 4;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  mode_strap = 2'b10;
  logic        neg_rail_strap = 1'b0;
  logic        neg_in = 1'b0;
  logic [7:0]  seen = 8'h00;
  logic [31:0] prdata, rd;
  logic [7:0]  sample_code;
  logic [2:0]  conv_chan;
  logic        pready, pslverr, conv_clk, sample_neg;
  logic        busy_n, sleep_active, er;
  int          n_fail = 0;
  int          n_checks = 0;

  always #10 clock = ~clock;

  amps_ctrl uut (.clock(clock), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mode_strap(mode_strap), .neg_rail_strap(neg_rail_strap),
    .conv_clk(conv_clk), .sample_code(sample_code),
    .sample_neg(sample_neg), .busy_n(busy_n),
    .sleep_active(sleep_active), .conv_chan(conv_chan));
  amps_front_model #(.HALF(P / 2)) u_front (.clock(clock),
    .conv_chan(conv_chan), .neg_in(neg_in), .conv_clk(conv_clk),
    .sample_code(sample_code), .sample_neg(sample_neg));

  // cleared while idle, so each run collects its own channels plus the last channel of the run before
  always @(posedge clock) begin
    seen <= busy_n ? 8'h00 : (seen | (8'h01 << conv_chan));
  end

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) chk(1'b0, "no pready");
  endtask : apb

  task automatic conv(input int n);
    int c;
    c = 0;
    while (busy_n === 1'b1 && c < 10) begin
      @(posedge clock);
      c++;
    end
    c = 0;
    while (busy_n !== 1'b1 && c < 2000) begin
      @(posedge clock);
      c++;
    end
    if (n > 0) chk(c >= n * 18 * P - P && c <= n * 18 * P + 8, "span");
  endtask : conv

  task automatic rd8(input logic [7:0] base, output int z);
    z = 0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RS, 32'h0);
      if (base != 8'h00) chk(rd[7:0] === base + 8'(i), "order");
      z += int'(rd[7:0] === 8'h00);
    end
  endtask : rd8

  initial begin
    int z;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, ST, 32'h0);
    chk(rd[3:0] === 4'h1, "status after reset");
    apb(1'b0, 8'h14, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, CW, 32'h0000_00AB);
    apb(1'b0, amps_pkg::REG_CHAN_CFG, 32'h0);
    chk(rd[4:0] === 5'h0B, "latched config");
    chk(busy_n === 1'b1, "suppressed start");
    $display("test config done");
    apb(1'b1, CW, 32'h0000_0060);
    repeat (2) @(posedge clock);
    chk(sleep_active === 1'b1, "sleep on");
    apb(1'b0, RS, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "read asleep");
    apb(1'b1, CW, 32'h0000_0040);
    repeat (20) @(posedge clock);
    chk(busy_n === 1'b1, "start asleep");
    apb(1'b0, ST, 32'h0);
    chk(rd[1] === 1'b1, "status sleep");
    apb(1'b1, CW, 32'h0000_0020);
    repeat (2) @(posedge clock);
    chk(sleep_active === 1'b0, "wake");
    // external reference kept up, so 50 us is enough
    repeat (2500) @(posedge clock);
    apb(1'b1, CW, 32'h0000_0080);
    // two channels need 144 cycles, so low busy_n after 200 shows the freeze
    ce <= 1'b0;
    repeat (200) @(posedge clock);
    chk(busy_n === 1'b0, "clock enable freeze");
    ce <= 1'b1;
    conv(0);
    chk(busy_n === 1'b1, "register run");
    $display("test sleep done");
    mode_strap <= 2'b00;
    repeat (40) @(posedge clock);
    apb(1'b1, CW, 32'h0);
    conv(8);
    chk(seen === 8'hFF, "eight singles");
    rd8(8'h10, z);
    mode_strap <= 2'b01;
    neg_in <= 1'b1;
    repeat (40) @(posedge clock);
    apb(1'b1, CW, 32'h0);
    conv(4);
    chk(seen === 8'hAA, "four pairs");
    rd8(8'h00, z);
    chk(z == 4, "wrong polarity gives zero");
    neg_rail_strap <= 1'b1;
    repeat (40) @(posedge clock);
    apb(1'b1, CW, 32'h0);
    conv(4);
    rd8(8'h00, z);
    chk(z == 0, "bipolar keeps sign");
    $display("test strapped done");
    test_done();
  end

  initial begin
    #400000;
    chk(1'b0, "timeout");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
